// ==== include/spcd_pkg.sv ====
package spcd_pkg;
    // Port geometry
    localparam int           PORT_WIDTH      = 6;
    localparam int           REG_WIDTH       = 8;
    localparam int           ADDR_WIDTH      = 8;
    localparam int           INPUT_ONLY_BIT  = 3;

    // Register byte offsets
    localparam logic [7:0]   OFS_PINS        = 8'h00;
    localparam logic [7:0]   OFS_DIRECTION   = 8'h04;
    localparam logic [7:0]   OFS_LATCH       = 8'h08;
    localparam logic [7:0]   OFS_ANALOG      = 8'h0c;
    localparam logic [7:0]   OFS_PULLUP      = 8'h10;
    localparam logic [7:0]   OFS_RISE_EN     = 8'h14;
    localparam logic [7:0]   OFS_FALL_EN     = 8'h18;
    localparam logic [7:0]   OFS_CHANGE_FLAG = 8'h1c;
    localparam logic [7:0]   OFS_CHANGE_EN   = 8'h20;
    localparam logic [7:0]   OFS_CONTROL     = 8'h24;

    // Control register fields
    localparam int           CTL_PULLUP_DIS  = 0;
    localparam int           CTL_MASTER_CLEAR_PIN_EN     = 1;

    // Implemented bit masks
    localparam logic [5:0]   LATCH_MASK      = 6'h37;
    localparam logic [5:0]   ANALOG_MASK     = 6'h17;
    localparam logic [5:0]   INPUT_ONLY_MASK = 6'h08;

    // Values after reset
    localparam logic [5:0]   DIRECTION_RST   = 6'h3f;
    localparam logic [5:0]   ANALOG_RST      = 6'h17;
    localparam logic [5:0]   PULLUP_RST      = 6'h3f;
    localparam logic [5:0]   ZERO6           = 6'h00;
    localparam logic [1:0]   CONTROL_RST     = 2'h1;

    // Bus responses
    localparam logic [1:0]   RESP_OKAY       = 2'h0;
    localparam logic [1:0]   RESP_SLVERR     = 2'h2;

    // Register selects
    typedef enum logic [3:0] {
        SPCD_SEL_PINS   = 4'h0,
        SPCD_SEL_DIR    = 4'h1,
        SPCD_SEL_LATCH  = 4'h2,
        SPCD_SEL_ANALOG = 4'h3,
        SPCD_SEL_PULLUP = 4'h4,
        SPCD_SEL_RISE   = 4'h5,
        SPCD_SEL_FALL   = 4'h6,
        SPCD_SEL_FLAG   = 4'h7,
        SPCD_SEL_CHGEN  = 4'h8,
        SPCD_SEL_CTL    = 4'h9,
        SPCD_SEL_NONE   = 4'hf
    } spcd_sel_e;
endpackage : spcd_pkg

// ==== hw/spcd_port.sv ====
// Notes on behaviour
// - Direction 1 input, 0 drives latch value.
// - Input-only pin never drives, direction reads 1.
// - Pin read gives levels; pin write updates latch.
// - Port write samples pins, modifies, stores latch.
// - Master clear enabled: input-only pin reads 0.
// - Analog pin reads zero, input buffer off.
// - Analog disables input, pull-up, change detect.
// - Analog select leaves digital output unaffected.
// - Highest priority enabled function owns pin.
// - Analog select bits are 1 after reset.
// - Pull-up needs enable bit and global permission.
// - Output direction switches pull-up off.
// - Power-on reset disables all pull-ups globally.
// - Input-only pull-up follows master clear mode.
// - Per-pin change enable, off after power-on.
// - Mismatch against last read sets change flag.
// - Change event can wake device from sleep.
// - Mismatch keeps setting flag until port access.
// - Last-read latch survives master clear, brown-out.
// - Change during port access may be missed.
// - Unimplemented bits read zero; pin writes hit latch.
// - Latch read returns latch, not pins.
// - Rising/falling enables set per-pin edge flags.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
module spcd_port #(
    parameter int PORT_W = spcd_pkg::PORT_WIDTH
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          softReset,
    // AXI4-Lite slave
    input  wire logic [spcd_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [spcd_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Pads
    input  wire logic [PORT_W-1:0]             padIn,
    output logic [PORT_W-1:0]                  padOut,
    output logic [PORT_W-1:0]                  padOe,
    output logic [PORT_W-1:0]                  padPullup,
    // Peripherals sharing the pins, high then low priority
    input  wire logic [PORT_W-1:0]             periphHiEn,
    input  wire logic [PORT_W-1:0]             periphHiData,
    input  wire logic [PORT_W-1:0]             periphLoEn,
    input  wire logic [PORT_W-1:0]             periphLoData,
    // Interrupt controller side
    output logic                               changeIntFlag,
    input  wire logic                          changeIntClear,
    output logic                               wakeRequest
);

    // Byte offset to register select
    function automatic spcd_pkg::spcd_sel_e decodeSel(input logic [spcd_pkg::ADDR_WIDTH-1:0] addr);
        logic [7:0] a;
        a = {addr[7:2], 2'b00};
        case (a)
            spcd_pkg::OFS_PINS:        decodeSel = spcd_pkg::SPCD_SEL_PINS;
            spcd_pkg::OFS_DIRECTION:   decodeSel = spcd_pkg::SPCD_SEL_DIR;
            spcd_pkg::OFS_LATCH:       decodeSel = spcd_pkg::SPCD_SEL_LATCH;
            spcd_pkg::OFS_ANALOG:      decodeSel = spcd_pkg::SPCD_SEL_ANALOG;
            spcd_pkg::OFS_PULLUP:      decodeSel = spcd_pkg::SPCD_SEL_PULLUP;
            spcd_pkg::OFS_RISE_EN:     decodeSel = spcd_pkg::SPCD_SEL_RISE;
            spcd_pkg::OFS_FALL_EN:     decodeSel = spcd_pkg::SPCD_SEL_FALL;
            spcd_pkg::OFS_CHANGE_FLAG: decodeSel = spcd_pkg::SPCD_SEL_FLAG;
            spcd_pkg::OFS_CHANGE_EN:   decodeSel = spcd_pkg::SPCD_SEL_CHGEN;
            spcd_pkg::OFS_CONTROL:     decodeSel = spcd_pkg::SPCD_SEL_CTL;
            default:                   decodeSel = spcd_pkg::SPCD_SEL_NONE;
        endcase
    endfunction : decodeSel

    // Low byte lane merge with old value
    function automatic logic [5:0] laneMerge(input logic [5:0] oldVal, input logic [31:0] data,
                                             input logic [3:0] strb);
        laneMerge = strb[0] ? data[5:0] : oldVal;
    endfunction : laneMerge

    // Registers
    logic [5:0]                 direction_r;
    logic [5:0]                 latch_r;
    logic [5:0]                 analog_r;
    logic [5:0]                 pullupEn_r;
    logic [5:0]                 riseEn_r;
    logic [5:0]                 fallEn_r;
    logic [5:0]                 changeEn_r;
    logic [5:0]                 edgeFlag_r;
    logic [5:0]                 lastRead_r;
    logic [5:0]                 prevPins_r;
    logic [1:0]                 control_r;
    logic                       changeIntFlag_r;

    // Bus state
    logic                       awTaken_r;
    logic                       wTaken_r;
    logic [spcd_pkg::ADDR_WIDTH-1:0] awAddr_r;
    logic [31:0]                wData_r;
    logic [3:0]                 wStrb_r;
    logic                       bvalid_r;
    logic [1:0]                 bresp_r;
    logic                       rvalid_r;
    logic [31:0]                rdata_r;
    logic [1:0]                 rresp_r;

    logic                       wrFire;
    logic                       rdFire;
    spcd_pkg::spcd_sel_e        wrSel;
    spcd_pkg::spcd_sel_e        rdSel;
    logic [5:0]                 pinLevels;
    logic [5:0]                 edgeFlag_nxt;
    logic [5:0]                 mismatch;
    logic                       mismatchAny;
    logic                       edgeEvent;
    logic                       portAccess;
    logic                       pullupDisable;
    logic                       mclrEnable;

    assign pullupDisable = control_r[spcd_pkg::CTL_PULLUP_DIS];
    assign mclrEnable    = control_r[spcd_pkg::CTL_MASTER_CLEAR_PIN_EN];

    // Bus handshakes
    assign s_axi_awready = !awTaken_r && !bvalid_r;
    assign s_axi_wready  = !wTaken_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign wrFire        = awTaken_r && wTaken_r && !bvalid_r;
    assign rdFire        = s_axi_arvalid && s_axi_arready;
    assign wrSel         = decodeSel(awAddr_r);
    assign rdSel         = decodeSel(s_axi_araddr);

    // Digital pin levels seen by software
    // analog reads zero
    assign pinLevels = padIn & ~analog_r & ~(mclrEnable ? spcd_pkg::INPUT_ONLY_MASK : spcd_pkg::ZERO6);

    // Pad drive with output priority
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (periphHiEn[i]) begin
                padOut[i] = periphHiData[i];
            end else if (periphLoEn[i]) begin
                padOut[i] = periphLoData[i];
            end else begin
                padOut[i] = latch_r[i];
            end
            padOe[i] = periphHiEn[i] || periphLoEn[i] || !direction_r[i];
        end
        padOe[spcd_pkg::INPUT_ONLY_BIT] = 1'b0;
    end

    // Weak pull-ups
    always_comb begin
        padPullup = pullupEn_r & direction_r & ~analog_r & ~{PORT_W{pullupDisable}};
        padPullup[spcd_pkg::INPUT_ONLY_BIT] = mclrEnable;
    end

    // Change detection
    // mismatch against last read
    assign mismatch    = (pinLevels ^ lastRead_r) & changeEn_r & ~analog_r;
    assign mismatchAny = |mismatch;
    assign portAccess  = (rdFire && rdSel == spcd_pkg::SPCD_SEL_PINS) ||
                         (wrFire && wrSel == spcd_pkg::SPCD_SEL_PINS);
    assign edgeEvent   = |(edgeFlag_nxt & ~edgeFlag_r);

    // Per-pin edge flag next value
    always_comb begin
        edgeFlag_nxt = edgeFlag_r;
        if (wrFire && wrSel == spcd_pkg::SPCD_SEL_FLAG && wStrb_r[0]) begin
            edgeFlag_nxt = edgeFlag_r & wData_r[5:0];
        end
        edgeFlag_nxt = edgeFlag_nxt | (((pinLevels & ~prevPins_r & riseEn_r) |
                                        (~pinLevels & prevPins_r & fallEn_r)) & ~analog_r);
    end

    // Write address and data capture
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awTaken_r <= 1'b0;
            wTaken_r  <= 1'b0;
            awAddr_r  <= '0;
            wData_r   <= 32'h0000_0000;
            wStrb_r   <= 4'h0;
        end else if (softReset || wrFire) begin
            awTaken_r <= 1'b0;
            wTaken_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awTaken_r <= 1'b1;
                awAddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wTaken_r <= 1'b1;
                wData_r  <= s_axi_wdata;
                wStrb_r  <= s_axi_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= spcd_pkg::RESP_OKAY;
        end else if (softReset) begin
            bvalid_r <= 1'b0;
        end else if (wrFire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wrSel == spcd_pkg::SPCD_SEL_NONE) ? spcd_pkg::RESP_SLVERR : spcd_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data path
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= spcd_pkg::RESP_OKAY;
        end else if (softReset) begin
            rvalid_r <= 1'b0;
        end else if (rdFire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= spcd_pkg::RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
            case (rdSel)
                spcd_pkg::SPCD_SEL_PINS:   rdata_r[5:0] <= pinLevels;
                spcd_pkg::SPCD_SEL_DIR:    rdata_r[5:0] <= direction_r | spcd_pkg::INPUT_ONLY_MASK;
                spcd_pkg::SPCD_SEL_LATCH:  rdata_r[5:0] <= latch_r & spcd_pkg::LATCH_MASK;
                spcd_pkg::SPCD_SEL_ANALOG: rdata_r[5:0] <= analog_r & spcd_pkg::ANALOG_MASK;
                spcd_pkg::SPCD_SEL_PULLUP: rdata_r[5:0] <= pullupEn_r;
                spcd_pkg::SPCD_SEL_RISE:   rdata_r[5:0] <= riseEn_r;
                spcd_pkg::SPCD_SEL_FALL:   rdata_r[5:0] <= fallEn_r;
                spcd_pkg::SPCD_SEL_FLAG:   rdata_r[5:0] <= edgeFlag_r;
                spcd_pkg::SPCD_SEL_CHGEN:  rdata_r[5:0] <= changeEn_r;
                spcd_pkg::SPCD_SEL_CTL:    rdata_r[1:0] <= control_r;
                default:                   rresp_r      <= spcd_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Configuration registers, restored to reset values by every reset except latch_r, which soft reset keeps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_r <= spcd_pkg::DIRECTION_RST;
            latch_r     <= spcd_pkg::ZERO6;
            analog_r    <= spcd_pkg::ANALOG_RST;
            pullupEn_r  <= spcd_pkg::PULLUP_RST;
            riseEn_r    <= spcd_pkg::ZERO6;
            fallEn_r    <= spcd_pkg::ZERO6;
            changeEn_r  <= spcd_pkg::ZERO6;
            control_r   <= spcd_pkg::CONTROL_RST;
        end else if (softReset) begin
            direction_r <= spcd_pkg::DIRECTION_RST;
            analog_r    <= spcd_pkg::ANALOG_RST;
            pullupEn_r  <= spcd_pkg::PULLUP_RST;
            riseEn_r    <= spcd_pkg::ZERO6;
            fallEn_r    <= spcd_pkg::ZERO6;
            changeEn_r  <= spcd_pkg::ZERO6;
            control_r   <= spcd_pkg::CONTROL_RST;
        end else if (wrFire) begin
            case (wrSel)
                spcd_pkg::SPCD_SEL_PINS:   latch_r     <= laneMerge(pinLevels, wData_r, wStrb_r)
                                                          & spcd_pkg::LATCH_MASK;
                spcd_pkg::SPCD_SEL_LATCH:  latch_r     <= laneMerge(latch_r, wData_r, wStrb_r)
                                                          & spcd_pkg::LATCH_MASK;
                spcd_pkg::SPCD_SEL_DIR:    direction_r <= laneMerge(direction_r, wData_r, wStrb_r);
                spcd_pkg::SPCD_SEL_ANALOG: analog_r    <= laneMerge(analog_r, wData_r, wStrb_r)
                                                          & spcd_pkg::ANALOG_MASK;
                spcd_pkg::SPCD_SEL_PULLUP: pullupEn_r  <= laneMerge(pullupEn_r, wData_r, wStrb_r);
                spcd_pkg::SPCD_SEL_RISE:   riseEn_r    <= laneMerge(riseEn_r, wData_r, wStrb_r);
                spcd_pkg::SPCD_SEL_FALL:   fallEn_r    <= laneMerge(fallEn_r, wData_r, wStrb_r);
                spcd_pkg::SPCD_SEL_CHGEN:  changeEn_r  <= laneMerge(changeEn_r, wData_r, wStrb_r);
                spcd_pkg::SPCD_SEL_CTL: begin
                    if (wStrb_r[0]) begin
                        control_r <= wData_r[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Last-read latch, power-on reset only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastRead_r <= spcd_pkg::ZERO6;
        end else if (portAccess) begin
            lastRead_r <= pinLevels;
        end
    end

    // Edge flags and pin history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeFlag_r <= spcd_pkg::ZERO6;
            prevPins_r <= spcd_pkg::ZERO6;
        end else if (softReset) begin
            edgeFlag_r <= spcd_pkg::ZERO6;
            prevPins_r <= pinLevels;
        end else begin
            edgeFlag_r <= edgeFlag_nxt;
            prevPins_r <= pinLevels;
        end
    end

    // Summary change flag, set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            changeIntFlag_r <= 1'b0;
        end else if ((mismatchAny && !portAccess) || edgeEvent) begin
            changeIntFlag_r <= 1'b1;
        end else if (changeIntClear) begin
            changeIntFlag_r <= 1'b0;
        end
    end

    assign changeIntFlag = changeIntFlag_r;
    assign wakeRequest   = changeIntFlag_r;

    // Input-only pin never driven
    AST_INPUT_ONLY_NO_DRIVE:
    assert property (@(posedge sys_clk) disable iff (!rst_n) !padOe[spcd_pkg::INPUT_ONLY_BIT])
        else $error("input-only pin driven");

    // Plain output follows latch
    AST_DIR_OUTPUT_LATCH:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!direction_r[0] && !periphHiEn[0] && !periphLoEn[0]) |-> (padOe[0] && padOut[0] == latch_r[0]))
        else $error("output pin not following latch");

    // Analog pins read zero
    AST_ANALOG_READ_ZERO:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rdFire && rdSel == spcd_pkg::SPCD_SEL_PINS) |=> ((s_axi_rdata[5:0] & $past(analog_r)) == 6'h00))
        else $error("analog pin read nonzero");

    // Output pins have no pull-up
    AST_PULLUP_OFF_OUTPUT:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((padPullup & ~direction_r & ~spcd_pkg::INPUT_ONLY_MASK) == 6'h00))
        else $error("pull-up on output pin");

    // Master clear hides input-only pin
    AST_MASTER_CLEAR_PIN_READS_ZERO:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rdFire && rdSel == spcd_pkg::SPCD_SEL_PINS && mclrEnable) |=> !s_axi_rdata[3])
        else $error("input-only pin visible under master clear");

    // Persistent mismatch keeps flag set
    AST_MISMATCH_SETS_FLAG:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mismatchAny && !portAccess) |=> changeIntFlag ##0 wakeRequest)
        else $error("mismatch failed to set change flag");

    // Analog select restored by soft reset
    AST_ANALOG_AFTER_RESET:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        softReset |=> (analog_r == spcd_pkg::ANALOG_RST))
        else $error("analog select not set after reset");

    // High priority peripheral owns pin
    AST_PRIORITY_PIN:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((padOut & periphHiEn) == (periphHiData & periphHiEn)))
        else $error("peripheral priority violated");

    // Last-read latch survives soft reset
    AST_LASTREAD_KEPT:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        softReset |=> $stable(lastRead_r))
        else $error("last-read latch lost on soft reset");

    // Enabled rising edge sets its flag
    AST_RISE_SETS_FLAG:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (riseEn_r[0] && !analog_r[0] && pinLevels[0] && !prevPins_r[0] && !softReset) |=> edgeFlag_r[0])
        else $error("rising edge flag not set");

endmodule : spcd_port

// ==== tb/spcd_pin_model.sv ====
module spcd_pin_model (
    input  wire logic [5:0] padOut,
    input  wire logic [5:0] padOe,
    input  wire logic [5:0] padPullup,
    input  wire logic [5:0] extLevel,
    input  wire logic [5:0] extDrive,
    output logic      [5:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wire level from port driver, outside source, pull-up, else the inverse of padOut
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (padOe[i]) padIn[i] = padOut[i];
            else if (extDrive[i]) padIn[i] = extLevel[i];
            else if (padPullup[i]) padIn[i] = 1'b1;
            else padIn[i] = ~padOut[i];
        end
    end
endmodule : spcd_pin_model

// ==== tb/spcd_port_tb.sv ====
module spcd_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, softReset, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, flag, clr, wake;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [5:0]  padIn, padOut, padOe, padPullup, hiEn, hiData, loEn, loData, extLevel, extDrive;
    int          nFail, nTests, cyc;

    spcd_port spcd_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .softReset(softReset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .periphHiEn(hiEn), .periphHiData(hiData), .periphLoEn(loEn), .periphLoData(loData),
        .changeIntFlag(flag), .changeIntClear(clr), .wakeRequest(wake));
    spcd_pin_model spcd_pin_model_inst (.padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .extLevel(extLevel), .extDrive(extDrive), .padIn(padIn));

    // Clock 200 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            nFail++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        check("rdata", {24'h000000, e}, d);
        check("rresp", spcd_pkg::RESP_OKAY, r);
    endtask : rdChk

    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, softReset, clr, rst_n} = '0;
        {awaddr, araddr, wdata, hiEn, hiData, loEn, loData, cyc, nFail, nTests} = '0;
        wstrb = 4'h1;
        extLevel = 6'h2b;
        extDrive = 6'h3f;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdChk(spcd_pkg::OFS_DIRECTION, 8'h3f);
        rdChk(spcd_pkg::OFS_ANALOG, 8'h17);
        rdChk(spcd_pkg::OFS_CONTROL, 8'h01);
        rdChk(spcd_pkg::OFS_CHANGE_EN, 8'h00);
        check("padPullup", 6'h00, padPullup);
        rd(8'h30);
        check("unmapped rresp", spcd_pkg::RESP_SLVERR, r);
        wr(8'h30, 8'h00);
        check("unmapped bresp", spcd_pkg::RESP_SLVERR, r);
        rdChk(spcd_pkg::OFS_PINS, 8'h28);
        wr(spcd_pkg::OFS_ANALOG, 8'h00);
        rdChk(spcd_pkg::OFS_PINS, 8'h2b);
        wr(spcd_pkg::OFS_CONTROL, 8'h02);
        rdChk(spcd_pkg::OFS_PINS, 8'h23);
        check("padPullup", 6'h3f, padPullup);
        wr(spcd_pkg::OFS_CONTROL, 8'h00);
        check("padPullup", 6'h37, padPullup);
        wr(spcd_pkg::OFS_ANALOG, 8'h01);
        check("padPullup", 6'h36, padPullup);
        $display("test reads and pull-ups done");
        wr(spcd_pkg::OFS_PINS, 8'hff);
        check("bresp", spcd_pkg::RESP_OKAY, r);
        wr(spcd_pkg::OFS_DIRECTION, 8'h00);
        check("padOe", 6'h37, padOe);
        check("padOut", 6'h37, padOut & padOe);
        check("padPullup", 6'h00, padPullup);
        rdChk(spcd_pkg::OFS_LATCH, 8'h37);
        rdChk(spcd_pkg::OFS_DIRECTION, 8'h08);
        wr(spcd_pkg::OFS_ANALOG, 8'h00);
        rdChk(spcd_pkg::OFS_PINS, 8'h3f);
        wr(spcd_pkg::OFS_LATCH, 8'h00);
        {hiEn, hiData, loEn, loData} <= {6'h10, 6'h00, 6'h10, 6'h10};
        @(posedge sys_clk);
        check("padOut hi wins", 1'b0, padOut[4]);
        hiEn <= 6'h00;
        @(posedge sys_clk);
        check("padOut lo wins", 1'b1, padOut[4]);
        loEn <= 6'h00;
        wr(spcd_pkg::OFS_DIRECTION, 8'h3e);
        wstrb <= 4'h0;
        wr(spcd_pkg::OFS_PINS, 8'h00);
        wstrb <= 4'h1;
        rdChk(spcd_pkg::OFS_LATCH, 8'h22);
        $display("test outputs done");
        wr(spcd_pkg::OFS_DIRECTION, 8'h3f);
        wr(spcd_pkg::OFS_CHANGE_EN, 8'h01);
        rd(spcd_pkg::OFS_PINS);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        @(posedge sys_clk);
        check("flag before change", 1'b0, flag);
        extLevel <= 6'h2a;
        repeat (3) @(posedge sys_clk);
        check("changeIntFlag", 1'b1, flag);
        check("wakeRequest", 1'b1, wake);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("flag held", 1'b1, flag);
        rd(spcd_pkg::OFS_PINS);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("flag cleared", 1'b0, flag);
        softReset <= 1'b1;
        @(posedge sys_clk);
        softReset <= 1'b0;
        extLevel  <= 6'h29;
        repeat (2) @(posedge sys_clk);
        check("flag after soft reset", 1'b0, flag);
        wr(spcd_pkg::OFS_ANALOG, 8'h00);
        wr(spcd_pkg::OFS_CHANGE_EN, 8'h02);
        repeat (3) @(posedge sys_clk);
        check("flag from kept latch", 1'b1, flag);
        wr(spcd_pkg::OFS_FALL_EN, 8'h20);
        wr(spcd_pkg::OFS_RISE_EN, 8'h01);
        extLevel <= 6'h08;
        repeat (2) @(posedge sys_clk);
        extLevel <= 6'h09;
        repeat (3) @(posedge sys_clk);
        rdChk(spcd_pkg::OFS_CHANGE_FLAG, 8'h21);
        wr(spcd_pkg::OFS_CHANGE_FLAG, 8'h00);
        rdChk(spcd_pkg::OFS_CHANGE_FLAG, 8'h00);
        $display("test change detect done");
        tally_and_finish();
    end
endmodule : spcd_port_tb
